/* include/spram_cfg.svh */
`ifndef SPRAM_CFG_SVH
`define SPRAM_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define APB_ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INFO 8'h08

// ****************************************
// Control fields
// ****************************************
`define CTRL_POLICY_LO 0
`define CTRL_POLICY_HI 1
`define CTRL_Q_REG 2
`define CTRL_Q_ACLR 3
`define CTRL_MASK_X 4
`define CTRL_IN_GATE 5
`define CTRL_OUT_GATE 6
`define CTRL_DUAL 7
`define CTRL_W 8
`define CTRL_RST 8'h01

// ****************************************
// Status and info fields
// ****************************************
`define STAT_RDW_HIT 0
`define STAT_ADDR_LO 16
`define INFO_WIDTH_LO 0
`define INFO_ADDR_W_LO 16

`endif

/* include/spram_pkg.sv */
package spram_pkg;

  typedef enum logic [1:0] {
    POLICY_DONT_CARE = 2'h0,
    POLICY_NEW_DATA = 2'h1,
    POLICY_OLD_DATA = 2'h2
  } rdw_policy_type;

  typedef struct packed {
    logic dual_clock;
    logic out_gate;
    logic in_gate;
    logic mask_x;
    logic q_aclr;
    logic q_reg;
    rdw_policy_type policy;
  } ctrl_type;

endpackage

/* src/single_port_ram.sv */
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "spram_cfg.svh"

// How it works
// [R1] Write data and read data equally wide
// [R2] Address hold keeps last registered address
// [R3] Clear empties input and read stages asynchronously
// [R4] Read output clear is separately selectable
// [R5] Single clock: one enable holds everything
// [R6] Dual clock: output stage on output enable
// [R7] Input and output gates enable own stages
// [R8] Each gate switched on independently
// [R9] Read width from listed values only
// [R10] Depth power of two, 32 to 65536
// [R11] Slice depth auto or 32 to 8192
// [R12] Inputs registered, output register optional
// [R13] Policy: don't care, new, old
// [R14] Don't care output not to be relied
// [R15] New data shows at the write edge
// [R16] Old data returns contents before write
// [R17] Masked bytes may read unknown
// [R18] Optional read strobe gates reads
// [R19] Store only while write strobe high
// [R20] Contents start zero or given fill
// [R21] Read output starts cleared
// [R22] New data: masked bytes show old
// [R23] Address width is log2 of depth

module single_port_ram
  import spram_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int BYTE_W = 8,
  parameter int MAX_SLICE = 0,
  parameter bit USE_LC = 1'b0,
  parameter bit USE_RDEN = 1'b0,
  parameter bit USE_ADDR_STALL = 1'b0,
  parameter logic [WIDTH-1:0] INIT_FILL = '0,
  parameter int ADDR_W = $clog2(DEPTH),
  parameter int BE_W = (WIDTH + BYTE_W - 1) / BYTE_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Clock gates and clear
  input wire logic clkena,
  input wire logic inclocken,
  input wire logic outclocken,
  input wire logic aclr,
  // Memory port
  input wire logic [WIDTH-1:0] data,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [BE_W-1:0] byteena,
  input wire logic wren,
  input wire logic rden,
  input wire logic addressstall,
  output logic [WIDTH-1:0] q,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  function automatic bit width_ok(input int w);
    return (w >= 1 && w <= 32) || w == 36 || w == 40 || w == 48 || w == 64 ||
      w == 72 || w == 108 || w == 128 || w == 144 || w == 256;
  endfunction

  function automatic bit pow2_in(input int v, input int lo, input int hi);
    return v >= lo && v <= hi && (v & (v - 1)) == 0;
  endfunction

  if (!width_ok(WIDTH)) begin : g_bad_width
    $error("Read width not in the allowed set"); // [R9]
  end
  if (!pow2_in(DEPTH, 32, 65536)) begin : g_bad_depth
    $error("Depth must be a power of two from 32 to 65536"); // [R10]
  end
  if (MAX_SLICE != 0 && (USE_LC || !pow2_in(MAX_SLICE, 32, 8192))) begin : g_bad_slice
    $error("Slice depth must be auto, or 32 to 8192 without logic cells"); // [R11]
  end
  if (ADDR_W != $clog2(DEPTH)) begin : g_bad_addr
    $error("Address width must be log2 of depth"); // [R23]
  end
  if (BE_W != (WIDTH + BYTE_W - 1) / BYTE_W) begin : g_bad_be
    $error("Byte enable width does not cover the data"); // [R1]
  end

  // ****************************************
  // Control register and clock gates
  // ****************************************
  ctrl_type ctrl;
  logic in_en;
  logic out_en;
  logic in_clr_b;
  logic q_clr_b;

  always_comb begin
    if (ctrl.dual_clock) begin
      in_en = !ctrl.in_gate || inclocken; // [R7] [R8]
      out_en = !ctrl.out_gate || outclocken; // [R6] [R7] [R8]
    end else begin
      in_en = clkena; // [R5]
      out_en = clkena; // [R5]
    end
  end

  // Clear is folded into the reset so that each stage keeps one async term
  assign in_clr_b = rst_b && !aclr; // [R3]
  assign q_clr_b = rst_b && !(aclr && ctrl.q_aclr); // [R4]

  // ****************************************
  // Input stage
  // ****************************************
  logic [ADDR_W-1:0] addr_hold;
  logic [ADDR_W-1:0] addr_eff;
  logic stall;
  logic read_on;

  assign stall = USE_ADDR_STALL && addressstall;
  assign addr_eff = stall ? addr_hold : address; // [R2]
  assign read_on = !USE_RDEN || rden; // [R18]

  always_ff @(posedge clock or negedge in_clr_b) begin
    if (!in_clr_b) begin
      addr_hold <= '0; // [R3]
    end else if (in_en && !stall) begin
      addr_hold <= address; // [R2] [R12]
    end
  end

  // ****************************************
  // Storage array
  // ****************************************
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] bit_mask;
  logic [WIDTH-1:0] old_word;
  logic [WIDTH-1:0] next_rd;

  // Preload is a fill value; a zero fill gives an empty memory
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = INIT_FILL; // [R20]
    end
  end

  always_comb begin
    bit_mask = '0;
    for (int b = 0; b < WIDTH; b++) begin
      bit_mask[b] = byteena[b / BYTE_W];
    end
  end

  assign old_word = mem[addr_eff];

  always_ff @(posedge clock) begin
    if (in_en && wren) begin
      mem[addr_eff] <= (data & bit_mask) | (old_word & ~bit_mask); // [R19]
    end
  end

  // ****************************************
  // Read during write
  // ****************************************
  logic [WIDTH-1:0] mask_fill;

  // Unknown fill only when asked for; otherwise old bytes are kept
  assign mask_fill = ctrl.mask_x ? {WIDTH{1'bx}} : old_word; // [R17]

  always_comb begin
    next_rd = old_word;
    if (wren) begin
      unique case (ctrl.policy)
        POLICY_NEW_DATA: begin
          next_rd = (data & bit_mask) | (mask_fill & ~bit_mask); // [R15] [R22]
        end
        POLICY_OLD_DATA: begin
          next_rd = (old_word & bit_mask) | (mask_fill & ~bit_mask); // [R16]
        end
        default: begin
          // Old contents returned; users may not rely on them
          next_rd = old_word; // [R14]
        end
      endcase
    end
  end

  // ****************************************
  // Read stage and output register
  // ****************************************
  logic [WIDTH-1:0] rd_word;

  always_ff @(posedge clock or negedge in_clr_b) begin
    if (!in_clr_b) begin
      rd_word <= '0; // [R3] [R21]
    end else if (in_en && read_on) begin
      rd_word <= next_rd; // [R12]
    end
  end

  always_ff @(posedge clock or negedge q_clr_b) begin
    if (!q_clr_b) begin
      q <= '0; // [R4] [R21]
    end else if (aclr) begin
      // While aclr is high, an output kept out of the clear must not load the cleared stage behind it
      q <= q; // [R4]
    end else if (!ctrl.q_reg) begin
      if (in_en && read_on) begin
        q <= next_rd; // [R15]
      end
    end else if (out_en) begin
      q <= rd_word; // [R12] [R6]
    end
  end

  // ****************************************
  // Read during write monitor
  // ****************************************
  logic rdw_hit;
  logic clr_hit;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdw_hit <= 1'b0;
    end else if (in_en && wren && read_on) begin
      rdw_hit <= 1'b1;
    end else if (clr_hit) begin
      rdw_hit <= 1'b0;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic access;
  logic hit_ctrl;
  logic hit_status;
  logic hit_info;
  logic [31:0] next_rdata;

  // One wait state keeps every bus output straight from a flop
  assign access = psel && penable && !pready;
  assign hit_ctrl = paddr == `OFS_CTRL;
  assign hit_status = paddr == `OFS_STATUS;
  assign hit_info = paddr == `OFS_INFO;
  assign clr_hit = access && pwrite && hit_status && pwdata[`STAT_RDW_HIT];

  always_comb begin
    next_rdata = 32'h0;
    if (hit_ctrl) begin
      next_rdata[`CTRL_W-1:0] = ctrl;
    end else if (hit_status) begin
      next_rdata[`STAT_RDW_HIT] = rdw_hit;
      next_rdata[`STAT_ADDR_LO +: 16] = 16'(addr_hold);
    end else if (hit_info) begin
      next_rdata[`INFO_WIDTH_LO +: 9] = 9'(WIDTH);
      next_rdata[`INFO_ADDR_W_LO +: 5] = 5'(ADDR_W);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= ctrl_type'(`CTRL_RST);
    end else if (access && pwrite && hit_ctrl) begin
      ctrl <= ctrl_type'(pwdata[`CTRL_W-1:0]); // [R8] [R13]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access;
      pslverr <= access && !(hit_ctrl || hit_status || hit_info);
      prdata <= (access && !pwrite) ? next_rdata : 32'h0;
    end
  end

endmodule

/* test/spram_checker_assertions.sv */
`timescale 1ns/1ps
module spram_checker #(
  parameter int WIDTH = 32,
  parameter bit USE_RDEN = 1'h0
) (
  // Watched ports
  input wire logic clock,
  input wire logic rst_b,
  input wire logic aclr,
  input wire logic rden,
  input wire logic [WIDTH-1:0] q,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_q_reset: assert property ($rose(rst_b) |-> q == '0) else $error("q not clear");
  a_read_hold: assert property ((USE_RDEN && !rden && !aclr) [*2] |=> ($stable(q) || aclr)) else $error("q moved");
  a_access_ready: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_map_err: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})) else $error("bad error");
endmodule
bind single_port_ram spram_checker #(.WIDTH(WIDTH), .USE_RDEN(USE_RDEN)) spram_checker_inst (.*);

/* test/ram_user_model.sv */
`timescale 1ns/1ps
module ram_user_model (
  // Clock and read pins
  input wire logic clock,
  input wire logic clkena,
  input wire logic rden,
  // Registered q: answer one edge later
  input wire logic slow,
  // High while q shows a fresh read
  output logic rd_seen
);
  logic taken;
  // ****
  // Read tracking
  // ****
  always_ff @(posedge clock) begin
    taken <= clkena & rden;
    rd_seen <= slow ? taken : clkena & rden;
  end
endmodule

/* test/tb_single_port_ram.sv */
`timescale 1ns/1ps
module tb_single_port_ram;
  // ****
  // Bench state
  // ****
  logic clock = 1'h0, rst_b = 1'h0, clkena = 1'h1, aclr = 1'h0, wren = 1'h0, rden = 1'h0;
  logic addressstall = 1'h0, inclocken = 1'h1, outclocken = 1'h1, slow = 1'h0, psel = 1'h0;
  logic penable = 1'h0, pwrite = 1'h0, pready, pslverr, rd_seen, e;
  logic [7:0] address = 8'h0, paddr = 8'h0;
  logic [3:0] byteena = 4'h0;
  logic [31:0] data = 32'h0, pwdata = 32'h0, q, prdata, r, wd;
  logic [31:0] exp_q[$];
  logic [15:0] seed = 16'hCB0D;
  int failures = 0, tests_run = 0;
  always #5 clock = ~clock;
  single_port_ram #(.USE_RDEN(1'h1), .USE_ADDR_STALL(1'h1)) single_port_ram_inst (.*);
  ram_user_model ram_user_model_inst (.*);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task final_report();
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      failures++;
      final_report();
    end
  endtask
  // Idle edge after each access keeps strobes from being driven twice in one step
  task op(input logic w, rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be, input logic [31:0] x);
    @(posedge clock);
    wren <= w;
    rden <= rd;
    address <= a;
    data <= d;
    byteena <= be;
    if (rd) begin
      exp_q.push_back(x);
    end
    @(posedge clock);
    wren <= 1'h0;
    rden <= 1'h0;
  endtask
  always @(posedge clock) begin
    if (rd_seen === 1'h1) begin
      chk(q, exp_q.pop_front());
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    int p;
    repeat (10) @(posedge clock);
    rst_b <= 1'h1;
    chk(q, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(r, 32'h1);
    op(1'h0, 1'h1, 8'h05, 32'h0, 4'h0, 32'h0);
    for (p = 0; p < 8; p++) begin
      seed = lfsr(seed);
      wd = {seed, ~seed};
      op(1'h1, 1'h0, seed[7:0] | 8'h80, wd, 4'hF, 32'h0);
      op(1'h0, 1'h1, seed[7:0] | 8'h80, ~wd, 4'hF, wd);
    end
    for (p = 0; p < 3; p++) begin
      apb(1'h1, 8'h00, 32'(p));
      op(1'h1, 1'h0, 8'h10, 32'h11223344, 4'hF, 32'h0);
      op(1'h1, 1'h1, 8'h10, 32'hAABBCCDD, 4'h3, p == 1 ? 32'h1122CCDD : 32'h11223344);
    end
    clkena <= 1'h0;
    op(1'h1, 1'h0, 8'h20, 32'h5A5A5A5A, 4'hF, 32'h0);
    clkena <= 1'h1;
    op(1'h0, 1'h1, 8'h20, 32'h0, 4'h0, 32'h0);
    op(1'h1, 1'h0, 8'h30, 32'h30, 4'hF, 32'h0);
    addressstall <= 1'h1;
    op(1'h0, 1'h1, 8'h31, 32'h0, 4'h0, 32'h30);
    addressstall <= 1'h0;
    for (p = 0; p < 2; p++) begin
      apb(1'h1, 8'h00, p ? 32'h6 : 32'hA);
      slow <= p[0];
      op(1'h0, 1'h1, 8'h30, 32'h0, 4'h0, 32'h30);
      @(posedge clock);
      aclr <= 1'h1;
      repeat (2) @(posedge clock);
      aclr <= 1'h0;
      chk(q, p ? 32'h30 : 32'h0);
    end
    apb(1'h0, 8'h04, 32'h0);
    chk(r, 32'h00300001);
    apb(1'h1, 8'h04, 32'h1);
    apb(1'h0, 8'h04, 32'h0);
    chk(r, 32'h00300000);
    apb(1'h0, 8'h08, 32'h0);
    chk(r, 32'h00080020);
    apb(1'h1, 8'h0C, 32'hFFFFFFFF);
    chk({31'h0, e}, 32'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk(r, 32'h0);
    final_report();
  end
endmodule
